// ===== rtl/clock_ctrl_pkg.sv
// package for the system clock and oscillator control unit
// assumes a 32-bit avalon-mm slave with word-aligned byte addresses
`default_nettype none
package clock_ctrl_pkg;
    // byte offsets
    localparam logic [7:0] OFF_INT_ENABLE = 8'h00;
    localparam logic [7:0] OFF_INT_DISABLE = 8'h04;
    localparam logic [7:0] OFF_INT_MASK_RD = 8'h08;
    localparam logic [7:0] OFF_INT_STATUS = 8'h0c;
    localparam logic [7:0] OFF_INT_CLEAR = 8'h10;
    localparam logic [7:0] OFF_CLK_STATUS = 8'h14;
    localparam logic [7:0] OFF_LOOP_CONF = 8'h18;
    localparam logic [7:0] OFF_LOOP_STEP = 8'h1c;
    localparam logic [7:0] OFF_REG_CTRL = 8'h20;
    localparam logic [7:0] OFF_GCLK_CTRL = 8'h24;
    localparam logic [7:0] OFF_SLEEP_CTRL = 8'h28;
    localparam logic [7:0] OFF_VER_BROWNOUT = 8'he0;
    localparam logic [7:0] OFF_VER_LOOP = 8'he4;
    localparam logic [7:0] OFF_VER_RC_CALIB = 8'he8;
    localparam logic [7:0] OFF_VER_SLOW_OSC = 8'hec;
    localparam logic [7:0] OFF_VER_REGULATOR = 8'hf0;
    localparam logic [7:0] OFF_VER_FAST_RC = 8'hf4;
    localparam logic [7:0] OFF_VER_TOP = 8'hfc;
    // event bit positions
    localparam int NUM_EVENTS = 6;
    localparam int EV_BROWNOUT = 0;
    localparam int EV_SUPPLY = 1;
    localparam int EV_REG_READY = 2;
    localparam int EV_COARSE_LOCK = 3;
    localparam int EV_FINE_LOCK = 4;
    localparam int EV_OSC_READY = 5;
    // loop configuration fields
    localparam int FINE_W = 9;
    localparam int COARSE_W = 5;
    localparam int STEP_W = 9;
    localparam int CONF_FINE_LSB = 0;
    localparam int CONF_COARSE_LSB = 16;
    localparam int CONF_ENABLE_BIT = 24;
    localparam int CONF_CLOSED_BIT = 25;
    localparam int CONF_DITHER_BIT = 26;
    localparam int REG_DEEP_OFF_BIT = 0;
    localparam int REG_OTHER_LSB = 1;
    localparam int REG_OTHER_W = 7;
    localparam int NUM_GCLK = 4;
    localparam int NUM_SOURCES = 4;
    localparam int GCLK_SRC_W = 2;
    localparam logic [FINE_W-1:0] FINE_OFFSET = 9'h002;
    localparam logic [FINE_W-1:0] FINE_RESET = 9'h000;
    localparam logic [COARSE_W-1:0] COARSE_RESET = 5'h00;
    localparam logic [STEP_W-1:0] STEP_RESET = 9'h004;
    // fine error above which the loop drops fine lock (4 codes, under 1 percent of the 512-code range)
    localparam logic [FINE_W-1:0] FINE_LOCK_WINDOW = 9'h004;
    // version codes: values are arbitrary
    localparam logic [31:0] VER_BROWNOUT = 32'h0000_0a10;
    localparam logic [31:0] VER_LOOP = 32'h0000_0a20;
    localparam logic [31:0] VER_RC_CALIB = 32'h0000_0a30;
    localparam logic [31:0] VER_SLOW_OSC = 32'h0000_0a40;
    localparam logic [31:0] VER_REGULATOR = 32'h0000_0a50;
    localparam logic [31:0] VER_FAST_RC = 32'h0000_0a60;
    localparam logic [31:0] VER_TOP = 32'h0000_0a70;
    localparam logic [31:0] UNMAPPED_VALUE = 32'h0000_0000;
endpackage : clock_ctrl_pkg
`default_nettype wire

// ===== rtl/fine_value_adjust.sv
// fine-tune value as the loop dac sees it
// assumes fine_in comes from a register on the same clock
`default_nettype none
module fine_value_adjust (
    input wire logic [clock_ctrl_pkg::FINE_W-1:0] fine_in,
    input wire logic closed_loop_in,
    input wire logic [clock_ctrl_pkg::FINE_W-1:0] track_in,
    output logic [clock_ctrl_pkg::FINE_W-1:0] dac_out
);
    wire logic [clock_ctrl_pkg::FINE_W-1:0] open_value;
    // modulo subtraction, 0/1/2 give 1fe/1ff/0
    assign open_value = fine_in - clock_ctrl_pkg::FINE_OFFSET; // RL3 RL4
    assign dac_out = closed_loop_in ? track_in : open_value;
endmodule : fine_value_adjust
`default_nettype wire

// ===== rtl/clock_ctrl.sv
// register interface and loop control of the clock and oscillator unit
// assumes an avalon-mm master on core_clk_in; event and lock pins are asynchronous
`default_nettype none
// Function
// RL1: a write to the interrupt clear register blocks every new interrupt event of that cycle.
// RL2: brown-out, supply, regulator-ready events then are lost, others stay in clock status.
// RL3: in open loop the dac gets the written fine value minus two.
// RL4: the subtraction wraps, so 0, 1 and 2 give 1fe, 1ff and 0.
// RL5: software sets the loop to minimum frequency, coarse zero, before disabling it.
// RL6: the regulator deep-mode-off bit always reads back as zero.
// RL7: below 30 MHz software programs a maximum step of seven or less.
// RL8: software programs a maximum step of at least four to avoid early coarse lock.
// RL9: the dither enable has no effect on the fine-tune output.
// RL10: with dithering off the loop can lose fine lock after getting it.
// RL11: in closed loop software uses a slow reference near 32 kHz.
// RL12: a source feeding an enabled generic clock keeps running in a source-stopping sleep.
// RL13: every sub-unit has a read-only version register with a fixed code.
module clock_ctrl (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [clock_ctrl_pkg::NUM_EVENTS-1:0] event_pins_in,
    input wire logic sleep_stop_sources_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic irq_out,
    output logic [clock_ctrl_pkg::FINE_W-1:0] dac_fine_out,
    output logic [clock_ctrl_pkg::COARSE_W-1:0] dac_coarse_out,
    output logic loop_enable_out,
    output logic regulator_deep_mode_off_out,
    output logic [clock_ctrl_pkg::NUM_SOURCES-1:0] source_run_out
);
    localparam int NE = clock_ctrl_pkg::NUM_EVENTS;
    localparam int FW = clock_ctrl_pkg::FINE_W;
    localparam int CW = clock_ctrl_pkg::COARSE_W;
    localparam int SW = clock_ctrl_pkg::STEP_W;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK = 2'b01
    } bus_state_t;

    bus_state_t bus_state_reg;
    bus_state_t bus_state_next;
    logic [NE-1:0] sync1_reg;
    logic [NE-1:0] sync2_reg;
    logic [NE-1:0] level_prev_reg;
    logic [NE-1:0] int_status_reg;
    logic [NE-1:0] int_mask_reg;
    logic [FW-1:0] fine_tune_value_reg;
    logic [CW-1:0] coarse_reg;
    logic loop_enable_reg;
    logic closed_loop_reg;
    logic dither_enable_reg;
    logic [SW-1:0] loop_max_step_reg;
    logic regulator_deep_mode_off_reg;
    logic [clock_ctrl_pkg::REG_OTHER_W-1:0] reg_other_reg;
    logic [clock_ctrl_pkg::NUM_GCLK-1:0] gclk_enable_reg;
    logic [clock_ctrl_pkg::NUM_GCLK*clock_ctrl_pkg::GCLK_SRC_W-1:0] gclk_src_reg;
    logic [clock_ctrl_pkg::NUM_SOURCES-1:0] source_on_reg;
    logic [FW-1:0] track_reg;
    logic fine_locked_reg;
    logic [31:0] readdata_reg;
    logic irq_reg;
    logic [FW-1:0] dac_fine_reg;
    logic [clock_ctrl_pkg::NUM_SOURCES-1:0] source_run_reg;

    // bus decode; one wait cycle on every access
    wire logic access = (avs_read_in | avs_write_in) && bus_state_reg == BUS_IDLE;
    wire logic wr = access && avs_write_in;
    wire logic be0 = avs_byteenable_in[0];
    wire logic be1 = avs_byteenable_in[1];
    wire logic be2 = avs_byteenable_in[2];
    wire logic be3 = avs_byteenable_in[3];
    wire logic wr_enable = wr && avs_address_in == clock_ctrl_pkg::OFF_INT_ENABLE;
    wire logic wr_disable = wr && avs_address_in == clock_ctrl_pkg::OFF_INT_DISABLE;
    wire logic wr_clear = wr && avs_address_in == clock_ctrl_pkg::OFF_INT_CLEAR;
    wire logic wr_conf = wr && avs_address_in == clock_ctrl_pkg::OFF_LOOP_CONF;
    wire logic wr_step = wr && avs_address_in == clock_ctrl_pkg::OFF_LOOP_STEP;
    wire logic wr_regctl = wr && avs_address_in == clock_ctrl_pkg::OFF_REG_CTRL;
    wire logic wr_gclk = wr && avs_address_in == clock_ctrl_pkg::OFF_GCLK_CTRL;
    wire logic wr_sleep = wr && avs_address_in == clock_ctrl_pkg::OFF_SLEEP_CTRL;

    // raw events: rising edges of the synchronised pins
    wire logic [NE-1:0] event_rise = sync2_reg & ~level_prev_reg;
    // a clear write swallows every event of its cycle
    wire logic [NE-1:0] event_set = wr_clear ? {NE{1'b0}} : event_rise; // RL1 RL2
    wire logic [NE-1:0] clear_bits = wr_clear && be0 ? avs_writedata_in[NE-1:0] : {NE{1'b0}};
    wire logic [NE-1:0] status_next = (int_status_reg & ~clear_bits) | event_set;
    wire logic [NE-1:0] mask_set = wr_enable && be0 ? avs_writedata_in[NE-1:0] : {NE{1'b0}};
    wire logic [NE-1:0] mask_clr = wr_disable && be0 ? avs_writedata_in[NE-1:0] : {NE{1'b0}};
    wire logic [NE-1:0] mask_next = (int_mask_reg | mask_set) & ~mask_clr;
    wire logic irq_next = |(status_next & mask_next);

    // live clock status: fine lock bit follows the loop, rest (coarse lock included) the pins
    wire logic [NE-1:0] clock_status;
    assign clock_status = {sync2_reg[clock_ctrl_pkg::EV_OSC_READY],
        fine_locked_reg, sync2_reg[clock_ctrl_pkg::EV_COARSE_LOCK],
        sync2_reg[clock_ctrl_pkg::EV_REG_READY:0]}; // RL2

    // closed-loop tracking: fine steps toward the written target, capped by max step
    wire logic [FW-1:0] target = fine_tune_value_reg;
    wire logic track_up = track_reg < target;
    wire logic [FW-1:0] track_err = track_up ? target - track_reg : track_reg - target;
    wire logic [FW-1:0] step_cap = loop_max_step_reg[FW-1:0];
    wire logic [FW-1:0] step = track_err > step_cap ? step_cap : track_err;
    wire logic [FW-1:0] track_next = track_up ? track_reg + step : track_reg - step;
    // no dither path: the enable bit is stored only
    wire logic [FW-1:0] dac_value; // RL9
    // fine lock may be dropped again once the error grows, there is no dither to hold it
    wire logic fine_lock_next = closed_loop_reg && loop_enable_reg
        && track_err <= clock_ctrl_pkg::FINE_LOCK_WINDOW; // RL10

    fine_value_adjust u_fine (
        .fine_in(fine_tune_value_reg),
        .closed_loop_in(closed_loop_reg),
        .track_in(track_reg),
        .dac_out(dac_value)
    );

    // sources needed by enabled generic clocks
    wire logic [clock_ctrl_pkg::NUM_SOURCES-1:0] gclk_need;
    genvar s;
    generate
        for (s = 0; s < clock_ctrl_pkg::NUM_SOURCES; s = s + 1) begin : g_need
            wire logic [clock_ctrl_pkg::NUM_GCLK-1:0] hit;
            genvar g;
            for (g = 0; g < clock_ctrl_pkg::NUM_GCLK; g = g + 1) begin : g_hit
                assign hit[g] = gclk_enable_reg[g] && gclk_src_reg[g*clock_ctrl_pkg::GCLK_SRC_W
                    +: clock_ctrl_pkg::GCLK_SRC_W] == clock_ctrl_pkg::GCLK_SRC_W'(s);
            end
            assign gclk_need[s] = |hit;
        end
    endgenerate
    // a needed source survives a source-stopping sleep
    wire logic [clock_ctrl_pkg::NUM_SOURCES-1:0] run_next = source_on_reg
        & (sleep_stop_sources_in ? gclk_need : {clock_ctrl_pkg::NUM_SOURCES{1'b1}}); // RL12

    // read mux
    wire logic [31:0] conf_word = {5'h00, dither_enable_reg, closed_loop_reg, loop_enable_reg,
        {(8-CW){1'b0}}, coarse_reg, {(16-FW){1'b0}}, fine_tune_value_reg};
    // deep-mode-off bit is not readable
    wire logic [31:0] regctl_word = {24'h000000, reg_other_reg, 1'b0}; // RL6
    logic [31:0] read_mux;
    always_comb begin
        unique case (avs_address_in)
            clock_ctrl_pkg::OFF_INT_MASK_RD: read_mux = {{(32-NE){1'b0}}, int_mask_reg};
            clock_ctrl_pkg::OFF_INT_STATUS: read_mux = {{(32-NE){1'b0}}, int_status_reg};
            clock_ctrl_pkg::OFF_CLK_STATUS: read_mux = {{(32-NE){1'b0}}, clock_status};
            clock_ctrl_pkg::OFF_LOOP_CONF: read_mux = conf_word;
            clock_ctrl_pkg::OFF_LOOP_STEP: read_mux = {{(32-SW){1'b0}}, loop_max_step_reg};
            clock_ctrl_pkg::OFF_REG_CTRL: read_mux = regctl_word;
            clock_ctrl_pkg::OFF_GCLK_CTRL: read_mux = {20'h00000, gclk_src_reg, gclk_enable_reg};
            clock_ctrl_pkg::OFF_SLEEP_CTRL: read_mux = {28'h0000000, source_on_reg};
            clock_ctrl_pkg::OFF_VER_BROWNOUT: read_mux = clock_ctrl_pkg::VER_BROWNOUT; // RL13
            clock_ctrl_pkg::OFF_VER_LOOP: read_mux = clock_ctrl_pkg::VER_LOOP; // RL13
            clock_ctrl_pkg::OFF_VER_RC_CALIB: read_mux = clock_ctrl_pkg::VER_RC_CALIB; // RL13
            clock_ctrl_pkg::OFF_VER_SLOW_OSC: read_mux = clock_ctrl_pkg::VER_SLOW_OSC; // RL13
            clock_ctrl_pkg::OFF_VER_REGULATOR: read_mux = clock_ctrl_pkg::VER_REGULATOR; // RL13
            clock_ctrl_pkg::OFF_VER_FAST_RC: read_mux = clock_ctrl_pkg::VER_FAST_RC; // RL13
            clock_ctrl_pkg::OFF_VER_TOP: read_mux = clock_ctrl_pkg::VER_TOP; // RL13
            default: read_mux = clock_ctrl_pkg::UNMAPPED_VALUE;
        endcase
    end

    always_comb begin
        unique case (bus_state_reg)
            BUS_IDLE: bus_state_next = access ? BUS_ACK : BUS_IDLE;
            BUS_ACK: bus_state_next = BUS_IDLE;
            default: bus_state_next = BUS_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            level_prev_reg <= '0;
        end else begin
            sync1_reg <= event_pins_in;
            sync2_reg <= sync1_reg;
            level_prev_reg <= sync2_reg;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            bus_state_reg <= BUS_IDLE;
            avs_waitrequest_out <= 1'b1;
            readdata_reg <= 32'h0000_0000;
            int_status_reg <= '0;
            int_mask_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            bus_state_reg <= bus_state_next;
            avs_waitrequest_out <= ~access;
            if (access) begin
                readdata_reg <= avs_read_in ? read_mux : 32'h0000_0000;
            end
            int_status_reg <= status_next;
            int_mask_reg <= mask_next;
            irq_reg <= irq_next;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            fine_tune_value_reg <= clock_ctrl_pkg::FINE_RESET;
            coarse_reg <= clock_ctrl_pkg::COARSE_RESET;
            loop_enable_reg <= 1'b0;
            closed_loop_reg <= 1'b0;
            dither_enable_reg <= 1'b0;
        end else if (wr_conf) begin
            if (be0) fine_tune_value_reg[7:0] <= avs_writedata_in[7:0];
            if (be1) fine_tune_value_reg[FW-1:8] <= avs_writedata_in[FW-1:8];
            if (be2) coarse_reg <= avs_writedata_in[clock_ctrl_pkg::CONF_COARSE_LSB +: CW];
            if (be3) begin
                loop_enable_reg <= avs_writedata_in[clock_ctrl_pkg::CONF_ENABLE_BIT];
                closed_loop_reg <= avs_writedata_in[clock_ctrl_pkg::CONF_CLOSED_BIT];
                dither_enable_reg <= avs_writedata_in[clock_ctrl_pkg::CONF_DITHER_BIT];
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            loop_max_step_reg <= clock_ctrl_pkg::STEP_RESET;
            regulator_deep_mode_off_reg <= 1'b0;
            reg_other_reg <= '0;
            gclk_enable_reg <= '0;
            gclk_src_reg <= '0;
            source_on_reg <= '0;
        end else begin
            if (wr_step && be0) loop_max_step_reg[7:0] <= avs_writedata_in[7:0];
            if (wr_step && be1) loop_max_step_reg[SW-1:8] <= avs_writedata_in[SW-1:8];
            if (wr_regctl && be0) begin
                regulator_deep_mode_off_reg <= avs_writedata_in[clock_ctrl_pkg::REG_DEEP_OFF_BIT];
                reg_other_reg <= avs_writedata_in[clock_ctrl_pkg::REG_OTHER_LSB +:
                    clock_ctrl_pkg::REG_OTHER_W];
            end
            if (wr_gclk && be0) gclk_enable_reg <= avs_writedata_in[clock_ctrl_pkg::NUM_GCLK-1:0];
            if (wr_gclk && be0) gclk_src_reg[3:0] <= avs_writedata_in[7:4];
            if (wr_gclk && be1) gclk_src_reg[7:4] <= avs_writedata_in[11:8];
            if (wr_sleep && be0) begin
                source_on_reg <= avs_writedata_in[clock_ctrl_pkg::NUM_SOURCES-1:0];
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            track_reg <= clock_ctrl_pkg::FINE_RESET;
            fine_locked_reg <= 1'b0;
            dac_fine_reg <= clock_ctrl_pkg::FINE_RESET;
            source_run_reg <= '0;
        end else begin
            track_reg <= (loop_enable_reg && closed_loop_reg) ? track_next : track_reg;
            fine_locked_reg <= fine_lock_next; // RL10
            dac_fine_reg <= dac_value; // RL3
            source_run_reg <= run_next;
        end
    end

    assign avs_readdata_out = readdata_reg;
    assign irq_out = irq_reg;
    assign dac_fine_out = dac_fine_reg;
    assign dac_coarse_out = coarse_reg;
    assign loop_enable_out = loop_enable_reg;
    assign regulator_deep_mode_off_out = regulator_deep_mode_off_reg;
    assign source_run_out = source_run_reg;
endmodule : clock_ctrl
`default_nettype wire

// ===== test/clock_ctrl_asserts.sv
// port-level checks for the clock and oscillator control unit
// assumes one clock domain and a master that holds each request until answered
`default_nettype none
module clock_ctrl_asserts (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic irq_out,
    input wire logic [clock_ctrl_pkg::FINE_W-1:0] dac_fine_out,
    input wire logic [clock_ctrl_pkg::COARSE_W-1:0] dac_coarse_out,
    input wire logic loop_enable_out,
    input wire logic regulator_deep_mode_off_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    wire logic take_wr = avs_write_in && avs_waitrequest_out;
    wire logic conf_wr = take_wr && avs_address_in == clock_ctrl_pkg::OFF_LOOP_CONF;
    wire logic regc_wr = take_wr && avs_address_in == clock_ctrl_pkg::OFF_REG_CTRL;
    wire logic clr_wr = take_wr && avs_address_in == clock_ctrl_pkg::OFF_INT_CLEAR;
    wire logic ack_rd = avs_read_in && !avs_waitrequest_out;
    wire logic open_wr = conf_wr && avs_byteenable_in == 4'hf && !avs_writedata_in[25];
    wire logic rd_regc = ack_rd && avs_address_in == clock_ctrl_pkg::OFF_REG_CTRL;
    wire logic rd_vtop = ack_rd && avs_address_in == clock_ctrl_pkg::OFF_VER_TOP;
    a_answer_next: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("bus answer not one cycle after request");
    a_ack_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low for more than one cycle");
    a_dac_open_loop: assert property (open_wr
        |-> ##2 dac_fine_out == $past(avs_writedata_in[8:0], 2) - 9'h002)
        else $error("open loop dac value wrong");
    a_coarse_direct: assert property (conf_wr && avs_byteenable_in[2]
        |=> dac_coarse_out == $past(avs_writedata_in[20:16])) else $error("coarse not applied");
    a_loop_enable: assert property (conf_wr && avs_byteenable_in[3]
        |=> loop_enable_out == $past(avs_writedata_in[24])) else $error("enable not applied");
    a_deep_off_stored: assert property (regc_wr && avs_byteenable_in[0]
        |=> regulator_deep_mode_off_out == $past(avs_writedata_in[0]))
        else $error("deep mode off bit not stored");
    a_deep_off_reads: assert property (rd_regc |-> !avs_readdata_out[0])
        else $error("deep mode off bit readable");
    a_version_top: assert property (rd_vtop
        |-> avs_readdata_out == clock_ctrl_pkg::VER_TOP) else $error("top version wrong");
    // a clear can only drop bits, so an idle irq must stay idle across it
    a_clear_blocks_new: assert property (clr_wr && !irq_out |=> !irq_out)
        else $error("event in clear cycle raised irq");
    c_conf_write: cover property (conf_wr);
    c_closed_write: cover property (conf_wr && avs_writedata_in[25]);
    c_clear_write: cover property (clr_wr);
    c_irq_rise: cover property ($rose(irq_out));
endmodule : clock_ctrl_asserts
bind clock_ctrl clock_ctrl_asserts chk_u (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .irq_out(irq_out), .dac_fine_out(dac_fine_out), .dac_coarse_out(dac_coarse_out),
    .loop_enable_out(loop_enable_out),
    .regulator_deep_mode_off_out(regulator_deep_mode_off_out));
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the clock and oscillator control unit
// assumes the one-cycle bus answer of clock_ctrl and no other bus master
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] adr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'hf;
    logic [5:0] ev = 6'h00;
    logic slp = 1'b0;
    logic [31:0] rdata, got, d;
    logic wreq, irq, len, doff;
    logic [8:0] dfine;
    logic [4:0] dcoarse;
    logic [3:0] srun;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;
    int fine, s, mask_m;
    logic [7:0] voff [7] = '{clock_ctrl_pkg::OFF_VER_BROWNOUT, clock_ctrl_pkg::OFF_VER_LOOP,
        clock_ctrl_pkg::OFF_VER_RC_CALIB, clock_ctrl_pkg::OFF_VER_SLOW_OSC,
        clock_ctrl_pkg::OFF_VER_REGULATOR, clock_ctrl_pkg::OFF_VER_FAST_RC,
        clock_ctrl_pkg::OFF_VER_TOP};
    logic [31:0] vval [7] = '{clock_ctrl_pkg::VER_BROWNOUT, clock_ctrl_pkg::VER_LOOP,
        clock_ctrl_pkg::VER_RC_CALIB, clock_ctrl_pkg::VER_SLOW_OSC,
        clock_ctrl_pkg::VER_REGULATOR, clock_ctrl_pkg::VER_FAST_RC, clock_ctrl_pkg::VER_TOP};
    clock_ctrl dut_u (.core_clk_in(clk), .reset_in(rst), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
        .event_pins_in(ev), .sleep_stop_sources_in(slp), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wreq), .irq_out(irq), .dac_fine_out(dfine),
        .dac_coarse_out(dcoarse), .loop_enable_out(len),
        .regulator_deep_mode_off_out(doff), .source_run_out(srun));
    initial forever #2 clk = ~clk;
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    // one bus access; the extra edge at the end keeps back-to-back calls race free
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        adr <= a;
        wd <= v;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wreq !== 1'b0 && cycles < 5000);
        got = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask : bus
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        got = $urandom(47);
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 7; i++) begin
            bus(1'b1, voff[i], 32'hffff_ffff);
            bus(1'b0, voff[i], 32'h0);
            check(got, vval[i]);
        end
        bus(1'b0, clock_ctrl_pkg::OFF_LOOP_STEP, 32'h0);
        check(got, 32'(clock_ctrl_pkg::STEP_RESET));
        bus(1'b0, 8'h80, 32'h0);
        check(got, clock_ctrl_pkg::UNMAPPED_VALUE);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            fine = (i < 3) ? i : $urandom % 512;
            d = {5'h0, 1'($urandom), 2'b01, 3'h0, 5'($urandom), 7'h0, 9'(fine)};
            bus(1'b1, clock_ctrl_pkg::OFF_LOOP_CONF, d);
            check(dfine, (fine + 510) % 512);
            check(dcoarse, d[20:16]);
            bus(1'b0, clock_ctrl_pkg::OFF_LOOP_CONF, 32'h0);
            check(got, d);
        end
        s = 4 + $urandom % 4;
        fine = $urandom % 512;
        bus(1'b1, clock_ctrl_pkg::OFF_LOOP_STEP, 32'(s));
        bus(1'b0, clock_ctrl_pkg::OFF_LOOP_STEP, 32'h0);
        check(got, s);
        // closed loop, slow reference, dither on: the dac walks to the target exactly
        bus(1'b1, clock_ctrl_pkg::OFF_LOOP_CONF, 32'h0700_0000 | fine);
        repeat (140) @(posedge clk);
        check(dfine, fine);
        bus(1'b0, clock_ctrl_pkg::OFF_CLK_STATUS, 32'h0);
        check(got[clock_ctrl_pkg::EV_FINE_LOCK], 1'b1);
        bus(1'b1, clock_ctrl_pkg::OFF_LOOP_CONF, 32'h0100_0000);
        bus(1'b1, clock_ctrl_pkg::OFF_LOOP_CONF, 32'h0);
        check(len, 1'b0);
        $display("test loop done");
        d = ($urandom % 256) | 32'h1;
        bus(1'b1, clock_ctrl_pkg::OFF_REG_CTRL, d);
        check(doff, 1'b1);
        be <= 4'he;
        bus(1'b1, clock_ctrl_pkg::OFF_REG_CTRL, 32'h0);
        be <= 4'hf;
        bus(1'b0, clock_ctrl_pkg::OFF_REG_CTRL, 32'h0);
        check(got, d & 32'hfe);
        $display("test regulator done");
        bus(1'b1, clock_ctrl_pkg::OFF_INT_ENABLE, 32'h3f);
        mask_m = 32'h3f;
        bus(1'b0, clock_ctrl_pkg::OFF_INT_MASK_RD, 32'h0);
        check(got, mask_m);
        for (int b = 0; b < 6; b++) begin
            ev <= 6'(1 << b);
            repeat (6) @(posedge clk);
            check(irq, 1'b1);
            bus(1'b0, clock_ctrl_pkg::OFF_INT_STATUS, 32'h0);
            check(got, 1 << b);
            bus(1'b1, clock_ctrl_pkg::OFF_INT_CLEAR, 32'($urandom) | (1 << b));
            ev <= 6'h0;
            repeat (3) @(posedge clk);
            check(irq, 1'b0);
            // event lands on the very edge that takes the clear write
            ev <= 6'(1 << b);
            repeat (2) @(posedge clk);
            bus(1'b1, clock_ctrl_pkg::OFF_INT_CLEAR, 32'h0);
            repeat (3) @(posedge clk);
            check(irq, 1'b0);
            bus(1'b0, clock_ctrl_pkg::OFF_INT_STATUS, 32'h0);
            check(got, 32'h0);
            if (b == clock_ctrl_pkg::EV_COARSE_LOCK || b == clock_ctrl_pkg::EV_OSC_READY) begin
                bus(1'b0, clock_ctrl_pkg::OFF_CLK_STATUS, 32'h0);
                check(got[b], 1'b1);
            end
            ev <= 6'h0;
            repeat (3) @(posedge clk);
        end
        bus(1'b1, clock_ctrl_pkg::OFF_INT_DISABLE, 32'h3f);
        mask_m = 0;
        ev <= 6'h01;
        repeat (6) @(posedge clk);
        check(irq, 1'b0);
        bus(1'b0, clock_ctrl_pkg::OFF_INT_STATUS, 32'h0);
        check(got, 32'h1);
        bus(1'b1, clock_ctrl_pkg::OFF_INT_MASK_RD, 32'h0);
        bus(1'b0, clock_ctrl_pkg::OFF_INT_MASK_RD, 32'h0);
        check(got, mask_m);
        $display("test interrupts done");
        bus(1'b1, clock_ctrl_pkg::OFF_SLEEP_CTRL, 32'hf);
        s = $urandom % 4;
        bus(1'b1, clock_ctrl_pkg::OFF_GCLK_CTRL, 32'h1 | (s << 4));
        slp <= 1'b1;
        repeat (3) @(posedge clk);
        check(srun, 1 << s);
        bus(1'b1, clock_ctrl_pkg::OFF_GCLK_CTRL, 32'h0);
        check(srun, 4'h0);
        slp <= 1'b0;
        repeat (3) @(posedge clk);
        check(srun, 4'hf);
        $display("test sleep done");
        conclude();
    end
endmodule : testbench
`default_nettype wire
